// ==== wiper_nv_seq.sv ====
`timescale 1ns/1ps
`include "wiper_nv_cfg.svh"
// Behaviour
// RQ1: master starts no transaction during store
// RQ2: store completes after 26 ms
// RQ3: preset midscale first, then restore nonvolatile
// RQ4: power-on restore finishes after 300 us
// RQ5: restore command reloads wiper in 300 us
// RQ6: master waits 540 us before nonvolatile write
// RQ7: serial clock at most 400 kHz
// RQ8: busy during operations; new requests deferred
module wiper_nv_seq (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       store_req,
   input  wire logic       restore_req,
   input  wire logic       wiper_wr,
   input  wire logic [7:0] wiper_wr_data,
   input  wire logic       scl_in,
   output logic      [7:0] wiper_ff,
   output logic            busy_ff,
   output logic            bus_block_ff,
   output logic            rewrite_ok_ff,
   output logic            store_done_ff,
   output logic            restore_done_ff,
   output logic            scl_fast_err_ff
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      wiper_nv_pkg::seq_state_t st;
      logic [`CNT_W-1:0]        cnt;
      logic [`CNT_W-1:0]        rw_cnt;
      logic                     rw_ok;
      logic                     st_pend;
      logic                     rs_pend;
      logic [7:0]               wiper;
      logic                     busy;
      logic                     blk;
      logic                     s_done;
      logic                     r_done;
      logic                     nv_we;
      logic [1:0]               scl_sync;
      logic                     scl_prev;
      logic [15:0]              scl_cnt;
      logic                     scl_err;
   } state_t;

   state_t s_ff;
   state_t nxt_s;
   logic [7:0] nv_rd;

   localparam logic [`CNT_W-1:0] STORE_N   = `CNT_W'(`STORE_CYCLES - 1);
   localparam logic [`CNT_W-1:0] RESTORE_N = `CNT_W'(`RESTORE_CYCLES - 1);
   localparam logic [`CNT_W-1:0] REWRITE_N = `CNT_W'(`REWRITE_CYCLES - 1);
   localparam logic [15:0]       SCL_MIN   = 16'(`SCL_MIN_CYCLES);

   // Timer expiry test shared by all timed states
   function automatic logic expired(input logic [`CNT_W-1:0] c, input logic [`CNT_W-1:0] lim);
      return c >= lim;
   endfunction : expired

   // ----------------------------------------------------------------
   // Nonvolatile cell
   // ----------------------------------------------------------------
   nv_cell u_nv (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (s_ff.nv_we),
      .wr_data (s_ff.wiper),
      .rd_data (nv_rd)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s        = s_ff;
      nxt_s.s_done = 1'b0;
      nxt_s.r_done = 1'b0;
      nxt_s.nv_we  = 1'b0;
      // Requests arriving while busy are remembered, not dropped
      if (store_req) nxt_s.st_pend = 1'b1;                       // RQ8
      if (restore_req) nxt_s.rs_pend = 1'b1;                     // RQ8
      // Rewrite guard timer runs from the power-on preset
      if (!s_ff.rw_ok) begin
         if (expired(s_ff.rw_cnt, REWRITE_N)) nxt_s.rw_ok = 1'b1; // RQ6
         else nxt_s.rw_cnt = s_ff.rw_cnt + 1'b1;
      end
      case (s_ff.st)
         wiper_nv_pkg::ST_PRESET: begin
            nxt_s.wiper = `WIPER_MIDSCALE;                       // RQ3
            nxt_s.cnt   = '0;
            nxt_s.st    = wiper_nv_pkg::ST_PWR_RESTORE;
         end
         wiper_nv_pkg::ST_PWR_RESTORE: begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
            if (expired(s_ff.cnt, RESTORE_N)) begin
               nxt_s.wiper  = nv_rd;                             // RQ3 RQ4
               nxt_s.busy   = 1'b0;
               nxt_s.r_done = 1'b1;
               nxt_s.st     = wiper_nv_pkg::ST_IDLE;
            end
         end
         wiper_nv_pkg::ST_IDLE: begin
            nxt_s.cnt = '0;
            // Store waits for the rewrite guard; restore has no such limit
            if (s_ff.st_pend && s_ff.rw_ok) begin
               nxt_s.st_pend = store_req;
               nxt_s.busy    = 1'b1;
               nxt_s.blk     = 1'b1;                             // RQ1
               nxt_s.nv_we   = 1'b1;
               nxt_s.st      = wiper_nv_pkg::ST_STORE;
            end else if (s_ff.rs_pend) begin
               nxt_s.rs_pend = restore_req;
               nxt_s.busy    = 1'b1;
               nxt_s.st      = wiper_nv_pkg::ST_RESTORE;
            end else if (wiper_wr) begin
               nxt_s.wiper = wiper_wr_data;
            end
         end
         wiper_nv_pkg::ST_STORE: begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
            if (expired(s_ff.cnt, STORE_N)) begin               // RQ2
               nxt_s.busy   = 1'b0;
               nxt_s.blk    = 1'b0;
               nxt_s.s_done = 1'b1;
               nxt_s.st     = wiper_nv_pkg::ST_IDLE;
            end
         end
         wiper_nv_pkg::ST_RESTORE: begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
            if (expired(s_ff.cnt, RESTORE_N)) begin             // RQ5
               nxt_s.wiper  = nv_rd;
               nxt_s.busy   = 1'b0;
               nxt_s.r_done = 1'b1;
               nxt_s.st     = wiper_nv_pkg::ST_IDLE;
            end
         end
         default: nxt_s.st = wiper_nv_pkg::ST_IDLE;
      endcase
      // SCL rate watch: rising edges closer than the 400 kHz period
      nxt_s.scl_sync = {s_ff.scl_sync[0], scl_in};
      nxt_s.scl_prev = s_ff.scl_sync[1];
      if (s_ff.scl_cnt != 16'hffff) nxt_s.scl_cnt = s_ff.scl_cnt + 16'h0001;
      if (s_ff.scl_sync[1] && !s_ff.scl_prev) begin
         if (s_ff.scl_cnt < SCL_MIN) nxt_s.scl_err = 1'b1;      // RQ7
         nxt_s.scl_cnt = 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_ff          <= '0;
         s_ff.st       <= wiper_nv_pkg::ST_PRESET;
         s_ff.wiper    <= `WIPER_MIDSCALE;
         s_ff.busy     <= 1'b1;
         s_ff.scl_cnt  <= 16'hffff;
         // Synchroniser starts at the idle-high level, so release shows no false edge
         s_ff.scl_sync <= 2'b11;
         s_ff.scl_prev <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs come straight from the state flops
   assign wiper_ff        = s_ff.wiper;
   assign busy_ff         = s_ff.busy;
   assign bus_block_ff    = s_ff.blk;
   assign rewrite_ok_ff   = s_ff.rw_ok;
   assign store_done_ff   = s_ff.s_done;
   assign restore_done_ff = s_ff.r_done;
   assign scl_fast_err_ff = s_ff.scl_err;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence store_start_s;
      s_ff.st == wiper_nv_pkg::ST_STORE && s_ff.cnt == '0;
   endsequence

   busy_in_store_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
      s_ff.st == wiper_nv_pkg::ST_STORE |-> busy_ff && bus_block_ff)
      else $error("busy or block low during store");

   store_len_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      $rose(store_done_ff) |-> $past(s_ff.cnt) == STORE_N)
      else $error("store ended at wrong count");

   store_full_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      s_ff.st == wiper_nv_pkg::ST_STORE && s_ff.cnt < STORE_N |=> s_ff.st == wiper_nv_pkg::ST_STORE)
      else $error("store ended before its full time");

   store_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
      store_start_s |-> rewrite_ok_ff)
      else $error("store started before rewrite guard");

   restore_len_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
      restore_done_ff |-> $past(s_ff.cnt) == RESTORE_N)
      else $error("restore ended at wrong count");

   preset_first_a: assert property (@(posedge clk) // RQ3
      $rose(rst_n) ##1 1'b1 |-> wiper_ff == `WIPER_MIDSCALE)
      else $error("wiper not midscale after reset");

   restore_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
      restore_done_ff |-> wiper_ff == $past(nv_rd) && !busy_ff)
      else $error("restore did not load cell value");

   block_store_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
      bus_block_ff |-> s_ff.st == wiper_nv_pkg::ST_STORE)
      else $error("bus block outside store");

   hold_wiper_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
      busy_ff && s_ff.st != wiper_nv_pkg::ST_PRESET && !restore_done_ff
      |=> wiper_ff == $past(wiper_ff) || restore_done_ff)
      else $error("wiper changed while busy");
endmodule : wiper_nv_seq

// ==== wiper_nv_cfg.svh ====
`ifndef WIPER_NV_CFG_SVH
`define WIPER_NV_CFG_SVH
// Clock rate and documented times
`define CLK_HZ           125000000
`define STORE_TIME_MS    26
`define RESTORE_TIME_US  300
`define REWRITE_TIME_US  540
`define SCL_MAX_KHZ      400
// Derived cycle counts (typical figures, taken as exact)
`define STORE_CYCLES     ((`CLK_HZ / 1000) * `STORE_TIME_MS)
`define RESTORE_CYCLES   ((`CLK_HZ / 1000000) * `RESTORE_TIME_US)
`define REWRITE_CYCLES   ((`CLK_HZ / 1000000) * `REWRITE_TIME_US)
// Shortest legal SCL period in clock cycles, rounded down
`define SCL_MIN_CYCLES   ((`CLK_HZ / 1000) / `SCL_MAX_KHZ)
// Wiper reset value
`define WIPER_MIDSCALE   8'h80
`define CNT_W            22
`endif

// ==== wiper_nv_pkg.sv ====
package wiper_nv_pkg;
   typedef enum logic [2:0] {
      ST_PRESET,
      ST_PWR_RESTORE,
      ST_IDLE,
      ST_STORE,
      ST_RESTORE
   } seq_state_t;
endpackage : wiper_nv_pkg

// ==== nv_cell.sv ====
`timescale 1ns/1ps
`include "wiper_nv_cfg.svh"
// ----------------------------------------------------------------
// Nonvolatile wiper cell model, registered read data
// ----------------------------------------------------------------
module nv_cell (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data
);
   // Factory content is midscale; a declaration value keeps the flop single-driven
   logic [7:0] mem_ff = `WIPER_MIDSCALE;

   // Cell content is not touched by reset, as in real nonvolatile storage
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_ff <= wr_data;
      end
   end

   // Read port registered; reset shows the factory midscale value
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= `WIPER_MIDSCALE;
      end else begin
         rd_data <= mem_ff;
      end
   end

endmodule : nv_cell

// ==== i2c_master_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus master model: serial clock frames, idle high between them
// ----------------------------------------------------------------
module i2c_master_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic bus_block,
   input  wire logic fast,
   output logic      scl
);
   int half_ff;
   int edges_ff;

   // Half period of 160 cycles gives a 2.56 us period, just under the top rate
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl      <= 1'b1;
         half_ff  <= 0;
         edges_ff <= 0;
      // Fast mode halves the period and breaks the limit on purpose, to exercise the watch
      end else if (half_ff >= (fast ? 79 : 159)) begin
         half_ff <= 0;
         if (edges_ff != 0) begin
            scl      <= ~scl;
            edges_ff <= edges_ff - 1;
         end else if (!bus_block) begin
            edges_ff <= 18;  // Nine pulses, ends high again
         end
      end else begin
         half_ff <= half_ff + 1;
      end
   end
endmodule : i2c_master_model

// ==== wiper_nv_seq_tb.sv ====
`timescale 1ns/1ps
`include "wiper_nv_cfg.svh"
module wiper_nv_seq_tb;
   // ----------------------------------------------------------------
   // Stimulus, design and bus master
   // ----------------------------------------------------------------
   logic       clk = 1'b0, rst_n = 1'b0, store_req = 1'b0, restore_req = 1'b0, wiper_wr = 1'b0;
   logic [7:0] wiper_wr_data = 8'h00, wiper_ff, v1, v2;
   logic       scl_in, busy_ff, bus_block_ff, rewrite_ok_ff, store_done_ff, restore_done_ff, scl_fast_err_ff;
   int         n_errors = 0, samples_checked = 0, seed = 32'h634593d8, n;
   logic       fast_scl = 1'b0;  // Master breaks the rate limit on purpose when set

   always #4 clk = ~clk;

   wiper_nv_seq wiper_nv_seq_inst (.clk(clk), .rst_n(rst_n), .store_req(store_req),
      .restore_req(restore_req), .wiper_wr(wiper_wr), .wiper_wr_data(wiper_wr_data),
      .scl_in(scl_in), .wiper_ff(wiper_ff), .busy_ff(busy_ff), .bus_block_ff(bus_block_ff),
      .rewrite_ok_ff(rewrite_ok_ff), .store_done_ff(store_done_ff),
      .restore_done_ff(restore_done_ff), .scl_fast_err_ff(scl_fast_err_ff));
   i2c_master_model i2c_master_model_inst (.clk(clk), .rst_n(rst_n), .bus_block(bus_block_ff),
      .fast(fast_scl), .scl(scl_in));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task check_val(string name, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val

   // The waiter starts up to two cycles after, or one cycle before, the restore itself
   function automatic logic restore_in_time(int cycles);
      return cycles >= `RESTORE_CYCLES - 2 && cycles <= `RESTORE_CYCLES + 1;
   endfunction : restore_in_time

   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   // Pulse one input for a single cycle; outputs sampled 1 ns after the edge
   task pulse(int which, logic [7:0] d);
      @(posedge clk);
      if (which == 0) begin
         store_req <= 1'b1;
      end else if (which == 1) begin
         restore_req <= 1'b1;
      end else begin
         wiper_wr      <= 1'b1;
         wiper_wr_data <= d;
      end
      @(posedge clk);
      store_req   <= 1'b0;
      restore_req <= 1'b0;
      wiper_wr    <= 1'b0;
      #1;
   endtask : pulse

   // Bounded wait for a restore end; n holds the cycles taken
   task wait_restore;
      n = 0;
      while (restore_done_ff !== 1'b1 && n < 40000) begin @(posedge clk); #1; n++; end
      if (n >= 40000) begin
         n_errors++;
         report_and_stop;
      end else begin
         check_val("restore_time", 8'h01, {7'h0, restore_in_time(n)});
      end
   endtask : wait_restore

   task power_up;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk); #1;
      check_val("preset_wiper", 8'h80, wiper_ff);
      check_val("preset_busy", 8'h01, {7'h0, busy_ff});
   endtask : power_up

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      v1 = $random(seed);
      v2 = $random(seed);
      if (v1 == 8'h80) v1 = 8'h81;  // Both must differ from the midscale cell content
      if (v2 == 8'h80) v2 = 8'h7f;
      power_up;
      pulse(2, v1);  // Ignored while the power-on restore runs
      wait_restore;
      check_val("pwr_restore", 8'h80, wiper_ff);
      check_val("early_rewrite", 8'h00, {7'h0, rewrite_ok_ff});
      $display("test power-on done");
      pulse(2, v1);
      check_val("wiper_write", v1, wiper_ff);
      pulse(1, 8'h00);
      wait_restore;
      check_val("cmd_restore", 8'h80, wiper_ff);
      $display("test restore done");
      n = 0;
      // The first store is only asked for once the rewrite guard has passed
      while (rewrite_ok_ff !== 1'b1 && n < 40000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 40000) begin
         n_errors++;
         report_and_stop;
      end
      pulse(2, v2);
      pulse(0, 8'h00);
      // The request pends for one cycle before the store starts
      @(posedge clk);
      #1;
      check_val("store_busy", 8'h03, {6'h0, busy_ff, bus_block_ff});
      pulse(1, 8'h00);  // Must pend behind the store
      pulse(2, ~v2);  // Must be ignored while busy
      repeat (2000) @(posedge clk);
      #1;
      check_val("store_hold", 8'h04, {5'h0, bus_block_ff, store_done_ff, restore_done_ff});
      check_val("store_wiper", v2, wiper_ff);
      check_val("scl_rate", 8'h00, {7'h0, scl_fast_err_ff});
      $display("test store done");
      fast_scl <= 1'b1;  // Frames after this reset run too fast for the limit
      power_up;
      wait_restore;
      check_val("kept_cell", v2, wiper_ff);
      pulse(0, 8'h00);  // Before the rewrite guard: must stay pending
      @(posedge clk);
      #1;
      check_val("early_store", 8'h00, {6'h0, busy_ff, bus_block_ff});
      check_val("scl_fast", 8'h01, {7'h0, scl_fast_err_ff});
      $display("test recall done");
      report_and_stop;
   end
endmodule : wiper_nv_seq_tb
